// File: src/param_bank_pkg.sv
// Constants for the controller status and parameter bank
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
package param_bank_pkg;

  //--------------------------------------------------------------------
  // Widths
  //--------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ALARM_N = 4;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  //--------------------------------------------------------------------
  // Parameter addresses
  //--------------------------------------------------------------------
  localparam logic [15:0] ADDR_FAST = 16'h004a;
  localparam logic [15:0] ADDR_DOUT_WORD = 16'h0050;
  localparam logic [15:0] ADDR_PV_MV = 16'h00cb;
  localparam logic [15:0] ADDR_TEST_EN = 16'h00cd;
  localparam logic [15:0] ADDR_BRK_TEST = 16'h00ce;
  localparam logic [15:0] ADDR_FILT_INIT = 16'h00cf;
  localparam logic [15:0] ADDR_SEG_MAX = 16'h00d3;
  localparam logic [15:0] ADDR_HOLD = 16'h0101;
  localparam logic [15:0] ADDR_BREAK = 16'h0102;
  localparam logic [15:0] ADDR_POWER = 16'h0103;
  localparam logic [15:0] ADDR_LOOP = 16'h0107;
  localparam logic [15:0] ADDR_INTEG = 16'h0108;
  localparam logic [15:0] ADDR_ALARM_ACK = 16'h0112;
  localparam logic [15:0] ADDR_RAMP_ACT = 16'h0113;
  localparam logic [15:0] ADDR_RAMP_DONE = 16'h0115;
  localparam logic [15:0] ADDR_HOLDBACK = 16'h0116;
  localparam logic [15:0] ADDR_KEYS = 16'h0117;
  localparam logic [15:0] ADDR_REMOTE = 16'h0118;
  localparam logic [15:0] ADDR_SYNC = 16'h0119;
  localparam logic [15:0] ADDR_DC_FAULT = 16'h011b;
  localparam logic [15:0] ADDR_IN_MAX = 16'h0224;
  localparam logic [15:0] ADDR_IN_MIN = 16'h0225;
  localparam logic [15:0] ADDR_SPAN = 16'h0228;

  //--------------------------------------------------------------------
  // Fast status byte layout
  //--------------------------------------------------------------------
  localparam int FB_ALARM = 0;
  localparam int FB_MANUAL = 4;
  localparam int FB_BREAK = 5;
  localparam int FB_LOOP = 6;
  localparam int FB_HEATER = 7;

  //--------------------------------------------------------------------
  // Defaults
  //--------------------------------------------------------------------
  localparam int SEG_MAX_DEFAULT = 16;
  localparam int DOUT_N_DEFAULT = 4;

endpackage

// File: src/controller_status_param_bank.sv
// Status flags, comms-only parameters and fast status byte
`timescale 1ns/1ns
`default_nettype none

module controller_status_param_bank #(
  parameter int SEG_MAX = param_bank_pkg::SEG_MAX_DEFAULT,
  parameter int DOUT_N = param_bank_pkg::DOUT_N_DEFAULT
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Parameter access
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic o_err,
  output logic [15:0] o_rdata,
  // Fast status read
  input wire logic i_fast_req,
  output logic o_fast_ack,
  output logic [7:0] o_fast_status,
  // Controller conditions
  input wire logic [3:0] i_alarm,
  input wire logic i_manual,
  input wire logic i_sensor_break,
  input wire logic i_test_break,
  input wire logic i_power_fail,
  input wire logic i_loop_break,
  input wire logic i_integral_hold,
  input wire logic i_ramp_active,
  input wire logic i_ramp_done,
  input wire logic i_remote_fault,
  input wire logic i_sync_wait,
  input wire logic i_remote_dc_fault,
  input wire logic i_heater_fail,
  input wire logic [15:0] i_input_max,
  input wire logic [15:0] i_input_min,
  input wire logic [15:0] i_target_span,
  input wire logic [DOUT_N-1:0] i_dout_unassigned,
  // Controls to the controller
  output logic [15:0] o_pv_mv,
  output logic o_test_point_en,
  output logic o_break_from_test,
  output logic o_filter_init,
  output logic o_control_hold,
  output logic o_alarm_ack,
  output logic o_holdback_off,
  output logic o_keypad_lock,
  output logic [DOUT_N-1:0] o_dout
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] snap_alarm;
    logic snap_manual;
    logic snap_break;
    logic snap_power;
    logic snap_loop;
    logic snap_integ;
    logic snap_ramp_act;
    logic snap_ramp_done;
    logic snap_remote;
    logic snap_sync;
    logic snap_dc_fault;
    logic snap_heater;
    logic [15:0] snap_max;
    logic [15:0] snap_min;
    logic [15:0] snap_span;
    logic ack;
    logic err;
    logic [15:0] rdata;
    logic fast_ack;
    logic [7:0] fast_byte;
    logic [15:0] pv_mv;
    logic test_en;
    logic brk_test;
    logic filt_init;
    logic hold;
    logic alarm_ack;
    logic holdback_off;
    logic keys_off;
    logic [DOUT_N-1:0] dout;
  } state_s;

  localparam logic [15:0] SEG_MAX_WORD = 16'(SEG_MAX);

  state_s st_reg;
  state_s st_next;

  // A one-bit flag read back as a full word
  function automatic logic [15:0] flag_word(input logic b);
    flag_word = {15'h0000, b};
  endfunction

  // Pack the fast byte from one snapshot so every bit is coherent
  function automatic logic [7:0] pack_fast(input state_s s);
    logic [7:0] f;
    f = param_bank_pkg::BYTE_ZERO;
    f[param_bank_pkg::FB_ALARM +: param_bank_pkg::ALARM_N] =
      s.snap_alarm;
    f[param_bank_pkg::FB_MANUAL] = s.snap_manual;
    f[param_bank_pkg::FB_BREAK] = s.snap_break;
    f[param_bank_pkg::FB_LOOP] = s.snap_loop;
    f[param_bank_pkg::FB_HEATER] = s.snap_heater;
    pack_fast = f;
  endfunction

  logic wr_hit;
  logic rd_hit;
  assign wr_hit = i_req & i_wr;
  assign rd_hit = i_req & ~i_wr;

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Snapshot all conditions together; reads see one sample
    st_next.snap_alarm = i_alarm;
    st_next.snap_manual = i_manual;
    // Break source chosen here so flag and fast bit always agree
    st_next.snap_break = st_reg.brk_test ? i_test_break
                                         : i_sensor_break;
    // Power fail is sticky until reset
    st_next.snap_power = st_reg.snap_power | i_power_fail;
    st_next.snap_loop = i_loop_break;
    st_next.snap_integ = i_integral_hold;
    st_next.snap_ramp_act = i_ramp_active;
    st_next.snap_ramp_done = i_ramp_done;
    st_next.snap_remote = i_remote_fault;
    st_next.snap_sync = i_sync_wait;
    st_next.snap_dc_fault = i_remote_dc_fault;
    st_next.snap_heater = i_heater_fail;
    st_next.snap_max = i_input_max;
    st_next.snap_min = i_input_min;
    st_next.snap_span = i_target_span;
    st_next.fast_byte = pack_fast(st_reg);
    st_next.fast_ack = i_fast_req;
    st_next.alarm_ack = 1'b0;
    st_next.ack = i_req;
    st_next.err = 1'b0;
    st_next.rdata = param_bank_pkg::WORD_ZERO;

    if (rd_hit) begin
      case (i_addr)
        param_bank_pkg::ADDR_FAST:
          st_next.rdata = {8'h00, pack_fast(st_reg)};
        param_bank_pkg::ADDR_DOUT_WORD:
          st_next.rdata = 16'(st_reg.dout);
        param_bank_pkg::ADDR_PV_MV:
          st_next.rdata = st_reg.pv_mv;
        param_bank_pkg::ADDR_TEST_EN:
          st_next.rdata = flag_word(st_reg.test_en);
        param_bank_pkg::ADDR_BRK_TEST:
          st_next.rdata = flag_word(st_reg.brk_test);
        param_bank_pkg::ADDR_FILT_INIT:
          st_next.rdata = flag_word(st_reg.filt_init);
        param_bank_pkg::ADDR_SEG_MAX:
          st_next.rdata = SEG_MAX_WORD;
        param_bank_pkg::ADDR_HOLD:
          st_next.rdata = flag_word(st_reg.hold);
        param_bank_pkg::ADDR_BREAK:
          st_next.rdata = flag_word(st_reg.snap_break);
        param_bank_pkg::ADDR_POWER:
          st_next.rdata = flag_word(st_reg.snap_power);
        param_bank_pkg::ADDR_LOOP:
          st_next.rdata = flag_word(st_reg.snap_loop);
        param_bank_pkg::ADDR_INTEG:
          st_next.rdata = flag_word(st_reg.snap_integ);
        // Acknowledge is a one-shot; it reads back the normal state
        param_bank_pkg::ADDR_ALARM_ACK:
          st_next.rdata = param_bank_pkg::WORD_ZERO;
        param_bank_pkg::ADDR_RAMP_ACT:
          st_next.rdata = flag_word(st_reg.snap_ramp_act);
        param_bank_pkg::ADDR_RAMP_DONE:
          st_next.rdata = flag_word(st_reg.snap_ramp_done);
        param_bank_pkg::ADDR_HOLDBACK:
          st_next.rdata = flag_word(st_reg.holdback_off);
        param_bank_pkg::ADDR_KEYS:
          st_next.rdata = flag_word(st_reg.keys_off);
        param_bank_pkg::ADDR_REMOTE:
          st_next.rdata = flag_word(st_reg.snap_remote);
        param_bank_pkg::ADDR_SYNC:
          st_next.rdata = flag_word(st_reg.snap_sync);
        param_bank_pkg::ADDR_DC_FAULT:
          st_next.rdata = flag_word(st_reg.snap_dc_fault);
        param_bank_pkg::ADDR_IN_MAX:
          st_next.rdata = st_reg.snap_max;
        param_bank_pkg::ADDR_IN_MIN:
          st_next.rdata = st_reg.snap_min;
        param_bank_pkg::ADDR_SPAN:
          st_next.rdata = st_reg.snap_span;
        default:
          st_next.err = 1'b1;
      endcase
    end

    if (wr_hit) begin
      case (i_addr)
        param_bank_pkg::ADDR_PV_MV:
          st_next.pv_mv = i_wdata;
        param_bank_pkg::ADDR_TEST_EN:
          st_next.test_en = i_wdata[0];
        param_bank_pkg::ADDR_BRK_TEST:
          st_next.brk_test = i_wdata[0];
        param_bank_pkg::ADDR_FILT_INIT:
          st_next.filt_init = i_wdata[0];
        param_bank_pkg::ADDR_HOLD:
          st_next.hold = i_wdata[0];
        param_bank_pkg::ADDR_ALARM_ACK:
          st_next.alarm_ack = i_wdata[0];
        param_bank_pkg::ADDR_HOLDBACK:
          st_next.holdback_off = i_wdata[0];
        param_bank_pkg::ADDR_KEYS:
          st_next.keys_off = i_wdata[0];
        // Outputs with a configured function keep their value
        param_bank_pkg::ADDR_DOUT_WORD:
          st_next.dout = (st_reg.dout & ~i_dout_unassigned) |
                         (i_wdata[DOUT_N-1:0] &
                          i_dout_unassigned);
        // Status words and read-only flags refuse writes
        default:
          st_next.err = 1'b1;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign o_ack = st_reg.ack;
  assign o_err = st_reg.err;
  assign o_rdata = st_reg.rdata;
  assign o_fast_ack = st_reg.fast_ack;
  assign o_fast_status = st_reg.fast_byte;
  assign o_pv_mv = st_reg.pv_mv;
  assign o_test_point_en = st_reg.test_en;
  assign o_break_from_test = st_reg.brk_test;
  assign o_filter_init = st_reg.filt_init;
  assign o_control_hold = st_reg.hold;
  assign o_alarm_ack = st_reg.alarm_ack;
  assign o_holdback_off = st_reg.holdback_off;
  assign o_keypad_lock = st_reg.keys_off;
  assign o_dout = st_reg.dout;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  a_seg_max_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    rd_hit && i_addr == param_bank_pkg::ADDR_SEG_MAX
    |=> o_ack && o_rdata == SEG_MAX_WORD && !o_err)
    else $error("segment maximum read wrong");

  a_seg_max_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    wr_hit && i_addr == param_bank_pkg::ADDR_SEG_MAX
    |=> o_ack && o_err)
    else $error("write to segment maximum not refused");

  a_test_en_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    wr_hit && i_addr == param_bank_pkg::ADDR_TEST_EN
    |=> o_test_point_en == $past(i_wdata[0]))
    else $error("test point enable not stored");

  a_break_source: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit && i_addr == param_bank_pkg::ADDR_BREAK
    ##1 o_ack
    |-> o_rdata == flag_word($past(o_break_from_test, 2) ?
         $past(i_test_break, 2) : $past(i_sensor_break, 2)))
    else $error("sensor break flag from wrong source");

  a_power_sticky: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    !$fell(st_reg.snap_power))
    else $error("power fail flag cleared");

  a_alarm_ack_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    wr_hit && i_addr == param_bank_pkg::ADDR_ALARM_ACK && i_wdata[0]
    |=> o_alarm_ack ##1 (!o_alarm_ack || $past(wr_hit)))
    else $error("alarm acknowledge pulse wrong");

  a_fast_alarms: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && i_fast_req ##1 o_fast_ack
    |-> o_fast_status[3:0] == $past(i_alarm, 2))
    else $error("fast byte alarm bits wrong");

  a_fast_same_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    rd_hit && i_addr == param_bank_pkg::ADDR_FAST
    |=> o_rdata == {8'h00, o_fast_status})
    else $error("fast byte read differs from fast status");

  a_dout_gated: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    ##1 ((o_dout ^ $past(o_dout)) & ~$past(i_dout_unassigned)) == '0)
    else $error("assigned digital output changed");

  a_ramp_done_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit &&
    i_addr == param_bank_pkg::ADDR_RAMP_DONE
    |=> o_rdata == flag_word($past(i_ramp_done, 2)))
    else $error("ramp complete flag wrong");

  // Snapshot reads are only judged once a real sample has been taken
  a_loop_flag_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit && i_addr == param_bank_pkg::ADDR_LOOP
    |=> o_rdata == flag_word($past(i_loop_break, 2)))
    else $error("loop break flag wrong");

  a_integ_flag_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit && i_addr == param_bank_pkg::ADDR_INTEG
    |=> o_rdata == flag_word($past(i_integral_hold, 2)))
    else $error("integral hold flag wrong");

  a_dc_fault_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit && i_addr == param_bank_pkg::ADDR_DC_FAULT
    |=> o_rdata == flag_word($past(i_remote_dc_fault, 2)))
    else $error("remote input fault flag wrong");

  a_in_max_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn) && rd_hit && i_addr == param_bank_pkg::ADDR_IN_MAX
    |=> o_rdata == $past(i_input_max, 2))
    else $error("maximum input value wrong");

  a_power_flag_set: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    i_power_fail |=> st_reg.snap_power)
    else $error("power fail not latched");

  a_ack_reads_zero: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    rd_hit && i_addr == param_bank_pkg::ADDR_ALARM_ACK
    |=> o_rdata == param_bank_pkg::WORD_ZERO && !o_err)
    else $error("acknowledge reads back non-zero");

  a_fast_manual: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn)
    |=> o_fast_status[param_bank_pkg::FB_MANUAL] == $past(i_manual, 2))
    else $error("fast byte manual bit wrong");

  a_fast_break_loop: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn)
    |=> o_fast_status[param_bank_pkg::FB_LOOP] == $past(i_loop_break, 2)
     && o_fast_status[param_bank_pkg::FB_BREAK] ==
        ($past(o_break_from_test, 2) ? $past(i_test_break, 2)
                                     : $past(i_sensor_break, 2)))
    else $error("fast byte break bits wrong");

  a_fast_heater: assert property (
    @(posedge i_sys_clk) disable iff (!i_resetn)
    $past(i_resetn)
    |=> o_fast_status[param_bank_pkg::FB_HEATER] == $past(i_heater_fail, 2))
    else $error("fast byte heater bit wrong");

endmodule

`default_nettype wire

// File: tb/param_master.sv
// Host-side model of the parameter master
`timescale 1ns/1ns
`default_nettype none

module param_master (
  // Clock
  input wire logic clk,
  // Request side
  output logic o_req,
  output logic o_wr,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata,
  // Answer side
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [15:0] i_rdata
);
  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 16'h5a5a;
    o_wdata = 16'ha5a5;
  end

  //--------------------------------------------------------------------
  // One access; a write drives the full 16-bit word on o_wdata
  //--------------------------------------------------------------------
  task automatic access(input logic wr, input logic [15:0] addr,
      input logic [15:0] wdata, output logic [15:0] rdata,
      output logic err);
    int n;
    n = 0;
    o_req = 1'b1;
    o_wr = wr;
    o_addr = addr;
    o_wdata = wdata;
    @(posedge clk);
    #1;
    o_req = 1'b0;
    // Released lines flip so a stale value never passes for a live one
    o_addr = ~addr;
    o_wdata = ~wdata;
    o_wr = ~wr;
    while (i_ack !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    rdata = i_rdata;
    err = (n < 8) ? i_err : 1'bx;
    // An edge passes so the next call never re-raises a just-lowered strobe
    @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the status and parameter bank
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req, wr_l, ack, err, fast_req = 1'b0, fast_ack;
  logic [15:0] addr, wdata, rdata, pv_mv;
  logic [15:0] imax = 16'h0000, imin = 16'h0000, span = 16'h0000;
  logic [15:0] c = 16'h0000;
  logic [7:0] fast_status;
  logic [3:0] unas = 4'b0000, dout;
  logic tp_en, brk_test, filt, hold, alarm_ack, hb_off, keys;
  int fail_count = 0;
  int total_checks = 0;
  int ack_pulses = 0;

  always #10 clk = ~clk;

  // Counts acknowledge cycles, so a stuck pulse counts more than once
  always @(negedge clk) begin
    if (alarm_ack === 1'b1) begin
      ack_pulses++;
    end
  end

  param_master m (.clk(clk), .o_req(req), .o_wr(wr_l), .o_addr(addr),
    .o_wdata(wdata), .i_ack(ack), .i_err(err), .i_rdata(rdata));

  controller_status_param_bank #(.SEG_MAX(8), .DOUT_N(4)) uut (
    .i_sys_clk(clk), .i_resetn(resetn), .i_req(req), .i_wr(wr_l),
    .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_err(err),
    .o_rdata(rdata), .i_fast_req(fast_req), .o_fast_ack(fast_ack),
    .o_fast_status(fast_status), .i_alarm(c[3:0]), .i_manual(c[4]),
    .i_sensor_break(c[5]), .i_test_break(c[8]), .i_power_fail(c[9]),
    .i_loop_break(c[6]), .i_integral_hold(c[10]), .i_ramp_active(c[11]),
    .i_ramp_done(c[12]), .i_remote_fault(c[13]), .i_sync_wait(c[14]),
    .i_remote_dc_fault(c[15]), .i_heater_fail(c[7]), .i_input_max(imax),
    .i_input_min(imin), .i_target_span(span), .i_dout_unassigned(unas),
    .o_pv_mv(pv_mv), .o_test_point_en(tp_en), .o_break_from_test(brk_test),
    .o_filter_init(filt), .o_control_hold(hold), .o_alarm_ack(alarm_ack),
    .o_holdback_off(hb_off), .o_keypad_lock(keys), .o_dout(dout));

  //--------------------------------------------------------------------
  // Shared helpers
  //--------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic w, input logic [15:0] a,
      input logic [15:0] v, input logic [15:0] exp, input logic eexp);
    logic [15:0] d;
    logic e;
    m.access(w, a, v, d, e);
    chk(d, exp, "access data");
    chk({15'h0000, e}, {15'h0000, eexp}, "access error");
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task automatic t_segments;
    acc(1'b0, 16'h00d3, 16'h0000, 16'h0008, 1'b0);
    acc(1'b1, 16'h00d3, 16'h0010, 16'h0000, 1'b1);
    acc(1'b0, 16'h00d3, 16'h0000, 16'h0008, 1'b0);
    acc(1'b0, 16'h0fff, 16'h0000, 16'h0000, 1'b1);
    $display("segments test done");
  endtask

  task automatic t_controls;
    acc(1'b1, 16'h00cb, 16'ha5c3, 16'h0000, 1'b0);
    chk(pv_mv, 16'ha5c3, "millivolt output");
    acc(1'b0, 16'h00cb, 16'h0000, 16'ha5c3, 1'b0);
    acc(1'b1, 16'h00cd, 16'h0001, 16'h0000, 1'b0);
    chk({15'h0000, tp_en}, 16'h0001, "test point enable");
    acc(1'b1, 16'h00ce, 16'h0001, 16'h0000, 1'b0);
    chk({15'h0000, brk_test}, 16'h0001, "break from test");
    c[8] = 1'b1;
    cyc(3);
    acc(1'b0, 16'h0102, 16'h0000, 16'h0001, 1'b0);
    acc(1'b1, 16'h00ce, 16'h0000, 16'h0000, 1'b0);
    cyc(3);
    acc(1'b0, 16'h0102, 16'h0000, 16'h0000, 1'b0);
    c[8] = 1'b0;
    $display("controls test done");
  endtask

  task automatic t_flags;
    logic [15:0] fa [9] = '{16'h0102, 16'h0103, 16'h0107, 16'h0108,
      16'h0113, 16'h0115, 16'h0118, 16'h0119, 16'h011b};
    int fi [9] = '{5, 9, 6, 10, 11, 12, 13, 14, 15};
    for (int i = 0; i < 9; i++) begin
      c[fi[i]] = 1'b0;
      cyc(3);
      acc(1'b0, fa[i], 16'h0000, 16'h0000, 1'b0);
      c[fi[i]] = 1'b1;
      cyc(3);
      acc(1'b0, fa[i], 16'h0000, 16'h0001, 1'b0);
      c[fi[i]] = 1'b0;
      cyc(3);
    end
    acc(1'b0, 16'h0103, 16'h0000, 16'h0001, 1'b0);
    imax = 16'h1234;
    cyc(3);
    acc(1'b0, 16'h0224, 16'h0000, 16'h1234, 1'b0);
    acc(1'b1, 16'h0224, 16'h0000, 16'h0000, 1'b1);
    $display("flags test done");
  endtask

  task automatic t_ack;
    int p0;
    p0 = ack_pulses;
    acc(1'b1, 16'h0112, 16'h0001, 16'h0000, 1'b0);
    chk(16'(ack_pulses - p0), 16'h0001, "ack pulse");
    chk({15'h0000, alarm_ack}, 16'h0000, "ack pulse end");
    acc(1'b0, 16'h0112, 16'h0000, 16'h0000, 1'b0);
    acc(1'b1, 16'h0112, 16'h0000, 16'h0000, 1'b0);
    chk(16'(ack_pulses - p0), 16'h0001, "no ack on zero");
    $display("alarm ack test done");
  endtask

  task automatic t_fast;
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      e = 8'h01 << b;
      c[7:0] = e;
      cyc(4);
      fast_req = 1'b1;
      @(posedge clk);
      #1;
      fast_req = 1'b0;
      chk({15'h0000, fast_ack}, 16'h0001, "fast ack");
      chk({8'h00, fast_status}, {8'h00, e}, "fast byte");
      acc(1'b0, 16'h004a, 16'h0000, {8'h00, e}, 1'b0);
    end
    acc(1'b1, 16'h004a, 16'h00ff, 16'h0000, 1'b1);
    c[7:0] = 8'h00;
    cyc(4);
    acc(1'b0, 16'h004a, 16'h0000, 16'h0000, 1'b0);
    $display("fast status test done");
  endtask

  task automatic t_dout;
    unas = 4'b0101;
    acc(1'b1, 16'h0050, 16'h000f, 16'h0000, 1'b0);
    chk({12'h000, dout}, 16'h0005, "unassigned outputs");
    acc(1'b0, 16'h0050, 16'h0000, 16'h0005, 1'b0);
    $display("digital output test done");
  endtask

  task automatic t_rw_flags;
    acc(1'b1, 16'h00cf, 16'h0001, 16'h0000, 1'b0);
    acc(1'b1, 16'h0101, 16'h0001, 16'h0000, 1'b0);
    acc(1'b1, 16'h0116, 16'h0001, 16'h0000, 1'b0);
    acc(1'b1, 16'h0117, 16'h0001, 16'h0000, 1'b0);
    chk({12'h000, filt, hold, hb_off, keys}, 16'h000f, "stored flags");
    acc(1'b0, 16'h00cf, 16'h0000, 16'h0001, 1'b0);
    acc(1'b0, 16'h0101, 16'h0000, 16'h0001, 1'b0);
    acc(1'b0, 16'h0116, 16'h0000, 16'h0001, 1'b0);
    acc(1'b0, 16'h0117, 16'h0000, 16'h0001, 1'b0);
    imin = 16'h0f0e;
    span = 16'h0c0d;
    cyc(3);
    acc(1'b0, 16'h0225, 16'h0000, 16'h0f0e, 1'b0);
    acc(1'b0, 16'h0228, 16'h0000, 16'h0c0d, 1'b0);
    acc(1'b1, 16'h00cf, 16'h0000, 16'h0000, 1'b0);
    chk({15'h0000, filt}, 16'h0000, "flag cleared");
    $display("stored flags test done");
  endtask

  task automatic t_reset;
    resetn = 1'b0;
    cyc(3);
    chk(pv_mv, 16'h0000, "millivolt after reset");
    chk({12'h000, dout}, 16'h0000, "outputs after reset");
    resetn = 1'b1;
    cyc(3);
    acc(1'b0, 16'h0103, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 16'h00cd, 16'h0000, 16'h0000, 1'b0);
    $display("reset test done");
  endtask

  //--------------------------------------------------------------------
  // Run control
  //--------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    // Well under 1000 cycles of traffic; this leaves a wide margin
    #200000;
    fail_count++;
    stop_test;
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_segments;
    t_controls;
    t_flags;
    t_ack;
    t_fast;
    t_dout;
    t_rw_flags;
    t_reset;
    stop_test;
  end
endmodule

`default_nettype wire
